// *** dac_ctrl_map.svh ***
// constants for the wiper latch and output shutdown control block
// assumes a single 125 MHz core clock; included by bare name
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH
`define CLK_PERIOD_NS 8
// shutdown entry and exit delays in ns, as timing constants
`define SHUTDOWN_ENTRY_DELAY_NS 10000
`define SHUTDOWN_EXIT_DELAY_NS 10000
// least times round up to whole cycles
`define SHUTDOWN_ENTRY_CYCLES \
  ((`SHUTDOWN_ENTRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHUTDOWN_EXIT_CYCLES \
  ((`SHUTDOWN_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// power-down selector codes
`define SHUTDOWN_SEL_NORMAL 2'h0
`define SHUTDOWN_SEL_PD_1K 2'h1
`define SHUTDOWN_SEL_PD_100K 2'h2
`define SHUTDOWN_SEL_OPEN 2'h3
// reference selector codes
`define REF_SEL_SUPPLY 2'h0
`define REF_SEL_BANDGAP 2'h1
`define REF_SEL_PIN_UNBUF 2'h2
`define REF_SEL_PIN_BUF 2'h3
`define DELAY_CNT_W 16
`endif

// *** dac_ctrl_pkg.sv ***
// types shared by the wiper latch and output shutdown control block
package dac_ctrl_pkg;
  typedef enum {st_normal, st_entering, st_down, st_exiting} shutdown_state_t;
  // analog controls for one channel
  typedef struct packed {
    logic amp_enable;
    logic ladder_connect;
    logic pulldown_1k;
    logic pulldown_100k;
    logic gain_two;
  } analog_ctrl_t;
endpackage

// *** dac_latch_and_powerdown_ctrl.sv ***
// wiper transfer hold, power-down sequencing and gain qualification
// for a multi-channel voltage DAC.
// assumes the serial front end writes code, selector and config inputs
// on clk, and that the hold pins are asynchronous.
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module dac_latch_and_powerdown_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter int HOLDS = 1,
  parameter int CODE_W = 12,
  parameter int ENTRY_CYCLES = `SHUTDOWN_ENTRY_CYCLES,
  parameter int EXIT_CYCLES = `SHUTDOWN_EXIT_CYCLES,
  parameter logic [CHANNELS-1:0] HOLD_MAP = '0
)
(
  input wire logic clk,
  input wire logic arst_n,
  // asynchronous hold pins
  input wire logic [HOLDS-1:0] wiper_transfer_hold,
  // power-on load of nonvolatile settings, one cycle pulse
  input wire logic nv_load,
  input wire logic [CHANNELS-1:0][CODE_W-1:0] nv_code,
  input wire logic [CHANNELS-1:0][1:0] nv_shutdown_sel,
  input wire logic [CHANNELS-1:0][1:0] nv_ref_sel,
  input wire logic [CHANNELS-1:0] nv_gain_sel,
  // serial writes into volatile registers, one cycle strobes
  input wire logic [CHANNELS-1:0] code_wr,
  input wire logic [CODE_W-1:0] code_wdata,
  input wire logic [CHANNELS-1:0] shutdown_wr,
  input wire logic [1:0] shutdown_wdata,
  input wire logic [CHANNELS-1:0] config_wr,
  input wire logic [1:0] ref_wdata,
  input wire logic gain_wdata,
  // volatile register readback
  output logic [CHANNELS-1:0][CODE_W-1:0] code_reg,
  output logic [CHANNELS-1:0][1:0] output_shutdown_sel,
  output logic [CHANNELS-1:0][1:0] reference_source_sel,
  output logic [CHANNELS-1:0] output_gain_sel,
  // analog side
  output logic [CHANNELS-1:0][CODE_W-1:0] wiper,
  output analog_ctrl_t [CHANNELS-1:0] analog_ctrl,
  output logic [CHANNELS-1:0] gain_request_illegal
);
  typedef struct packed {
    logic [CHANNELS-1:0][CODE_W-1:0] code;
    logic [CHANNELS-1:0][CODE_W-1:0] wiper;
    logic [CHANNELS-1:0][1:0] sd_sel;
    logic [CHANNELS-1:0][1:0] ref_sel;
    logic [CHANNELS-1:0] gain;
  } ctrl_state_t;
  ctrl_state_t c_r;
  ctrl_state_t c_nxt;
  logic [HOLDS-1:0] hold_s;
  logic [CHANNELS-1:0] amp_on;
  logic [CHANNELS-1:0] ladder_on;
  logic [CHANNELS-1:0] pd_1k;
  logic [CHANNELS-1:0] pd_100k;

  // one synchroniser per hold pin
  genvar h;
  generate
    for (h = 0; h < HOLDS; h++)
    begin : g_hold
      hold_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(wiper_transfer_hold[h]),
        .sync_out(hold_s[h])
      );
    end
  endgenerate

  // register writes and wiper transfer; channels on the same hold share
  // one synchronised level, so they all release on the same edge
  always_comb
  begin
    c_nxt = c_r;
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (nv_load)
      begin
        c_nxt.code[i] = nv_code[i];
        c_nxt.sd_sel[i] = nv_shutdown_sel[i];
        c_nxt.ref_sel[i] = nv_ref_sel[i];
        c_nxt.gain[i] = nv_gain_sel[i];
      end
      else
      begin
        // writes accepted in every power-down mode and under hold
        if (code_wr[i])
          c_nxt.code[i] = code_wdata;
        if (shutdown_wr[i])
          c_nxt.sd_sel[i] = shutdown_wdata;
        if (config_wr[i])
        begin
          c_nxt.ref_sel[i] = ref_wdata;
          c_nxt.gain[i] = gain_wdata;
        end
      end
      // power-down touches none of these registers
      if (!hold_s[HOLD_MAP[i] ? 1 : 0])
        c_nxt.wiper[i] = c_r.code[i];
      // held: wiper keeps its value
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      c_r <= '0;
    else
      c_r <= c_nxt;
  end

  // independent sequencer per channel
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      shutdown_seq #(
        .ENTRY_CYCLES(ENTRY_CYCLES),
        .EXIT_CYCLES(EXIT_CYCLES)
      ) u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .output_shutdown_sel(c_r.sd_sel[ch]),
        .amp_on(amp_on[ch]),
        .ladder_on(ladder_on[ch]),
        .pd_1k(pd_1k[ch]),
        .pd_100k(pd_100k[ch])
      );

      // analog controls; gain forced to unity on supply reference
      always_comb
      begin
        analog_ctrl[ch].amp_enable = amp_on[ch];
        analog_ctrl[ch].ladder_connect = ladder_on[ch];
        analog_ctrl[ch].pulldown_1k = pd_1k[ch];
        analog_ctrl[ch].pulldown_100k = pd_100k[ch];
        analog_ctrl[ch].gain_two = c_r.gain[ch] &&
          (c_r.ref_sel[ch] != `REF_SEL_SUPPLY);
      end

      // flags a host that asked for gain two on the supply reference
      assign gain_request_illegal[ch] = c_r.gain[ch] &&
        (c_r.ref_sel[ch] == `REF_SEL_SUPPLY);
    end
  endgenerate

  assign code_reg = c_r.code;
  assign wiper = c_r.wiper;
  assign output_shutdown_sel = c_r.sd_sel;
  assign reference_source_sel = c_r.ref_sel;
  assign output_gain_sel = c_r.gain;
endmodule // dac_latch_and_powerdown_ctrl

// *** dac_latch_and_powerdown_ctrl_bench.sv ***
// self-checking bench: the host model drives writes and the hold pin
// assumes shortened shutdown delays of 4 cycles to keep the run brief
`timescale 1ns/10ps
module dac_latch_and_powerdown_ctrl_bench;
  import dac_ctrl_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hold;
  logic nv_load;
  logic [5:0] strb;
  logic [11:0] wdata;
  logic [1:0][11:0] code_reg;
  logic [1:0][1:0] sd_sel;
  logic [1:0][11:0] wiper;
  logic [1:0][1:0] ref_sel;
  logic [1:0] gain_sel;
  analog_ctrl_t [1:0] ac;
  logic [1:0] illegal;
  int fails = 0;
  int num_checks = 0;
  int n;
  always #4 clk = ~clk;
  host_model host (.clk(clk), .hold(hold), .nv_load(nv_load), .strb(strb), .wdata(wdata));
  // channel 0 stores supply reference with gain set, channel 1 powers up down
  dac_latch_and_powerdown_ctrl #(.ENTRY_CYCLES(4), .EXIT_CYCLES(4)) uut (.clk(clk),
    .arst_n(arst_n), .wiper_transfer_hold(hold), .nv_load(nv_load),
    .nv_code({12'h5A5, 12'hA5A}), .nv_shutdown_sel({2'h1, 2'h0}), .nv_ref_sel({2'h1, 2'h0}),
    .nv_gain_sel(2'h3), .code_wr(strb[1:0]), .code_wdata(wdata), .shutdown_wr(strb[3:2]),
    .shutdown_wdata(wdata[1:0]), .config_wr(strb[5:4]), .ref_wdata(wdata[1:0]),
    .gain_wdata(wdata[2]), .code_reg(code_reg), .output_shutdown_sel(sd_sel),
    .reference_source_sel(ref_sel), .output_gain_sel(gain_sel), .wiper(wiper), .analog_ctrl(ac),
    .gain_request_illegal(illegal));
  task automatic chk_v(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_ac(input string what, input analog_ctrl_t exp, input analog_ctrl_t got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence: load, hold and release, power-down modes, gain rules
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk_ac("reset", 5'h18, ac[0]);
    host.nvld();
    wait_n(12);
    chk_v("nv code", 12'hA5A, code_reg[0]);
    chk_v("nv sel", 12'h001, 12'(sd_sel[1]));
    chk_v("wiper", 12'hA5A, wiper[0]);
    chk_v("pd 1k", 12'h001, 12'(ac[1].pulldown_1k));
    host.set_hold(1'b1);
    wait_n(4);
    host.wr(0, 2'h3, 12'h123);
    wait_n(6);
    chk_v("held code", 12'h123, code_reg[0]);
    chk_v("down code", 12'h123, code_reg[1]);
    chk_v("held w0", 12'hA5A, wiper[0]);
    chk_v("held w1", 12'h5A5, wiper[1]);
    host.set_hold(1'b0);
    for (n = 0; n < 10 && wiper[0] !== 12'h123; n++)
      wait_n(1);
    if (n == 10)
    begin
      fails++;
      give_verdict();
    end
    chk_v("w1 same edge", 12'h123, wiper[1]);
    // each mode is entered from normal and left by writing 00
    for (int m = 1; m < 4; m++)
    begin
      host.wr(1, 2'h1, 12'(m));
      wait_n(12);
      chk_ac("down", analog_ctrl_t'(m == 1 ? 5'h04 : m == 2 ? 5'h02 : 5'h00), ac[0]);
      chk_v("kept", 12'h123, code_reg[0]);
      chk_v("other sel", 12'h001, 12'(sd_sel[1]));
      host.wr(1, 2'h1, 12'h000);
      #1;
      chk_v("amp wait", 12'h000, 12'(ac[0].amp_enable));
      // ladder back at once, amp still off until the exit delay runs out
      wait_n(4);
      chk_ac("exit wait", 5'h08, ac[0]);
      wait_n(1);
      chk_ac("up", 5'h18, ac[0]);
    end
    // entry cut short by a write of 00, then a mode change while down
    host.wr(1, 2'h1, 12'h001);
    host.wr(1, 2'h1, 12'h000);
    wait_n(8);
    chk_ac("abort", 5'h18, ac[0]);
    host.wr(1, 2'h1, 12'h001);
    wait_n(12);
    host.wr(1, 2'h1, 12'h002);
    wait_n(1);
    chk_ac("mode change", 5'h02, ac[0]);
    host.wr(1, 2'h1, 12'h000);
    wait_n(12);
    chk_ac("back up", 5'h18, ac[0]);
    // gain with supply reference is a deliberate bad request
    for (int r = 0; r < 4; r++)
    begin
      host.wr(2, 2'h1, 12'h004 | 12'(r));
      #1;
      chk_v("gain", 12'(r != 0), 12'(ac[0].gain_two));
      chk_v("flag", 12'(r == 0), 12'(illegal[0]));
      chk_v("ref sel", 12'(r), 12'(ref_sel[0]));
      chk_v("gain sel", 12'h001, 12'(gain_sel[0]));
    end
    give_verdict();
  end
endmodule // dac_latch_and_powerdown_ctrl_bench

// *** dac_latch_and_powerdown_ctrl_checker.sv ***
// checker for the wiper hold and shutdown block, channel 0 mostly
// bound into the design; sequence lengths assume 4-cycle shutdown delays
`timescale 1ns/10ps
module dlp_checker
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter int HOLDS = 1,
  parameter int CODE_W = 12,
  parameter int ENTRY_CYCLES = 4,
  parameter int EXIT_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [HOLDS-1:0] wiper_transfer_hold,
  input wire logic nv_load,
  input wire logic [CHANNELS-1:0] code_wr,
  input wire logic [CODE_W-1:0] code_wdata,
  input wire logic [CHANNELS-1:0] shutdown_wr,
  input wire logic [CHANNELS-1:0][CODE_W-1:0] code_reg,
  input wire logic [CHANNELS-1:0][1:0] output_shutdown_sel,
  input wire logic [CHANNELS-1:0][1:0] reference_source_sel,
  input wire logic [CHANNELS-1:0] output_gain_sel,
  input wire logic [CHANNELS-1:0][CODE_W-1:0] wiper,
  input wire analog_ctrl_t [CHANNELS-1:0] analog_ctrl,
  input wire logic [CHANNELS-1:0] gain_request_illegal
);
  logic [1:0] sel;
  logic [1:0] prev_r;
  logic [3:0] age_r;
  analog_ctrl_t ac;
  assign sel = output_shutdown_sel[0];
  assign ac = analog_ctrl[0];
  // selector age saturates, so a long steady run needs no wide counter
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      prev_r <= 2'h0;
      age_r <= 4'h0;
    end
    else
    begin
      prev_r <= sel;
      age_r <= (sel != prev_r) ? 4'h0 : (age_r == 4'hF ? age_r : age_r + 4'h1);
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_amp_holds;
    ac.amp_enable [*4];
  endsequence
  sequence s_exit;
    (ac.ladder_connect && !ac.pulldown_1k && !ac.pulldown_100k && !ac.amp_enable) [*4]
      ##1 (ac.amp_enable && ac.ladder_connect);
  endsequence
  property p_entry;
    sel != 2'h0 && $past(sel) == 2'h0 && ac.amp_enable |->
      s_amp_holds ##1 ac.amp_enable ##1 (!ac.amp_enable || sel == 2'h0);
  endproperty
  property p_down;
    sel != 2'h0 && sel == prev_r && int'(age_r) > ENTRY_CYCLES + 4 |-> !ac.amp_enable
      && !ac.ladder_connect && ac.pulldown_1k == (sel == 2'h1) && ac.pulldown_100k == (sel == 2'h2);
  endproperty
  property p_exit;
    sel == 2'h0 && $past(sel) != 2'h0 && !ac.amp_enable |=> s_exit;
  endproperty
  property p_gain_sup;
    reference_source_sel[0] == 2'h0 |-> !ac.gain_two && gain_request_illegal[0] == output_gain_sel[0];
  endproperty
  property p_gain_ok;
    reference_source_sel[0] != 2'h0 |-> ac.gain_two == output_gain_sel[0] && !gain_request_illegal[0];
  endproperty
  property p_code_wr;
    code_wr[0] && !nv_load |=> code_reg[0] == $past(code_wdata);
  endproperty
  property p_sel_keep;
    !shutdown_wr[0] && !nv_load |=> $stable(sel);
  endproperty
  property p_hold;
    wiper_transfer_hold[0] [*4] |=> $stable(wiper[0]) && $stable(wiper[1]);
  endproperty
  property p_follow;
    !wiper_transfer_hold[0] [*4] |=> wiper[0] == $past(code_reg[0]) && wiper[1] == $past(code_reg[1]);
  endproperty
  a_entry: assert property (p_entry)
    else $error("amplifier off at the wrong time");
  a_down: assert property (p_down)
    else $error("wrong power-down outputs");
  a_exit: assert property (p_exit)
    else $error("wrong exit sequence");
  a_gain_sup: assert property (p_gain_sup)
    else $error("gain not unity on supply reference");
  a_gain_ok: assert property (p_gain_ok)
    else $error("gain select not applied");
  a_code_wr: assert property (p_code_wr)
    else $error("code write lost");
  a_sel_keep: assert property (p_sel_keep)
    else $error("selector moved without a write");
  a_hold: assert property (p_hold)
    else $error("wiper moved while held");
  a_follow: assert property (p_follow)
    else $error("wiper not following code");
endmodule // dlp_checker

bind dac_latch_and_powerdown_ctrl dlp_checker #(.CHANNELS(CHANNELS), .HOLDS(HOLDS),
  .CODE_W(CODE_W), .ENTRY_CYCLES(ENTRY_CYCLES), .EXIT_CYCLES(EXIT_CYCLES)) chk (.*);

// *** hold_sync.sv ***
// two-flop synchroniser for the asynchronous wiper transfer hold level
// assumes input arrives from a pin with no relation to clk
`timescale 1ns/10ps
module hold_sync
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;
  sync_state_t st_r;
  sync_state_t st_nxt;

  // first stage read only by the second; reset high keeps wipers frozen
  always_comb
  begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= 2'h3;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.stable;
endmodule // hold_sync

// *** host_model.sv ***
// host model: drives the volatile register writes and the hold pin
// strobes last one cycle; data lines show junk between writes
`timescale 1ns/10ps
module host_model
(
  input wire logic clk,
  output logic hold,
  output logic nv_load,
  output logic [5:0] strb,
  output logic [11:0] wdata
);
  // idle host keeps the hold low
  initial
  begin
    hold = 1'b0;
    nv_load = 1'b0;
    strb = 6'h00;
    wdata = 12'hFFF;
  end
  // kind 0 code, 1 shutdown, 2 config; ch is a channel mask
  task automatic wr(input int kind, input logic [1:0] ch, input logic [11:0] d);
    @(posedge clk);
    strb <= 6'(ch) << (2 * kind);
    wdata <= d;
    @(posedge clk);
    strb <= 6'h00;
    wdata <= ~d; // released lines must not keep the last value
  endtask
  // pin moves off the clock edge, as a real external driver would
  task automatic set_hold(input logic v);
    @(posedge clk);
    #3;
    hold <= v;
  endtask
  // power-on load of the stored settings
  task automatic nvld();
    @(posedge clk);
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
  endtask
endmodule // host_model

// *** shutdown_seq.sv ***
// per-channel power-down sequencer with entry and exit delays
// assumes selector changes only on serial writes or at reset load
`timescale 1ns/10ps
`include "dac_ctrl_map.svh"
module shutdown_seq
  import dac_ctrl_pkg::*;
#(
  parameter int ENTRY_CYCLES = `SHUTDOWN_ENTRY_CYCLES,
  parameter int EXIT_CYCLES = `SHUTDOWN_EXIT_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] output_shutdown_sel,
  output logic amp_on,
  output logic ladder_on,
  output logic pd_1k,
  output logic pd_100k
);
  typedef struct packed {
    shutdown_state_t state;
    logic [`DELAY_CNT_W-1:0] cnt;
    logic amp;
    logic ladder;
    logic [1:0] pd_code;
  } seq_state_t;
  seq_state_t s_r;
  seq_state_t s_nxt;
  logic want_down;

  assign want_down = (output_shutdown_sel != `SHUTDOWN_SEL_NORMAL);

  // entry: amp keeps driving for the entry delay, then amp and ladder go off and the 1k or 100k pulldown engages as selected
  // exit: ladder and circuits re-enable at once, amp drives after exit delay
  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.state)
      st_normal:
      begin
        if (want_down)
        begin
          s_nxt.state = st_entering;
          s_nxt.cnt = `DELAY_CNT_W'(ENTRY_CYCLES - 1);
        end
      end
      st_entering:
      begin
        if (!want_down)
          s_nxt.state = st_normal; // aborted before taking effect
        else if (s_r.cnt == '0)
        begin
          s_nxt.state = st_down;
          s_nxt.amp = 1'b0;
          s_nxt.ladder = 1'b0;
          s_nxt.pd_code = output_shutdown_sel;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      st_down:
      begin
        s_nxt.pd_code = output_shutdown_sel; // mode may change while down
        if (!want_down)
        begin
          s_nxt.state = st_exiting;
          s_nxt.ladder = 1'b1;
          s_nxt.pd_code = `SHUTDOWN_SEL_NORMAL;
          s_nxt.cnt = `DELAY_CNT_W'(EXIT_CYCLES - 1);
        end
      end
      st_exiting:
      begin
        if (want_down)
        begin
          s_nxt.state = st_down;
          s_nxt.ladder = 1'b0;
          s_nxt.pd_code = output_shutdown_sel;
        end
        else if (s_r.cnt == '0)
        begin
          s_nxt.state = st_normal;
          s_nxt.amp = 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r.state <= st_normal;
      s_r.cnt <= '0;
      s_r.amp <= 1'b1;
      s_r.ladder <= 1'b1;
      s_r.pd_code <= `SHUTDOWN_SEL_NORMAL;
    end
    else
      s_r <= s_nxt;
  end

  assign amp_on = s_r.amp;
  assign ladder_on = s_r.ladder;
  assign pd_1k = (s_r.pd_code == `SHUTDOWN_SEL_PD_1K);
  assign pd_100k = (s_r.pd_code == `SHUTDOWN_SEL_PD_100K);
endmodule // shutdown_seq
